// ### logic/ssw_pkg.sv
// Constants for the secure starvation watchdog
package ssw_pkg;
	// Timeout period in microseconds and derived cycle count at 100 MHz
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned TIMEOUT_US = 1000;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int CNT_W = 32;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	// Counter value at which a stage expires
	localparam logic [31:0] CNT_LAST = 32'h0000_0001;
	// One-hot escalation states
	typedef enum logic [3:0] {
		SSW_IDLE = 4'h1,
		SSW_RUN = 4'h2,
		SSW_IRQ = 4'h4,
		SSW_VIOL = 4'h8
	} ssw_state_t;
endpackage : ssw_pkg

// ### logic/ssw_secure_starvation_watchdog.sv
// Secure starvation watchdog: timeout counter with two-stage escalation
`timescale 1ns/1ns
module ssw_secure_starvation_watchdog #(
	parameter logic [31:0] TIMEOUT_CYCLES = 32'(ssw_pkg::TIMEOUT_CYC)
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Requests from the processor side, one-cycle pulses
	input wire logic activate,
	input wire logic deactivate,
	input wire logic service,
	input wire logic req_secure,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_period,
	// Status and escalation outputs
	output logic active,
	output logic secure_world_irq,
	output logic security_policy_unit_violation
);
	// Escalation state, running period and countdown
	ssw_pkg::ssw_state_t state_q;
	ssw_pkg::ssw_state_t state_d;
	logic [31:0] period_q;
	logic [31:0] period_d;
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic irq_q;
	logic irq_d;
	logic viol_q;
	logic viol_d;
	// Next values of the registered outputs
	logic active_d;
	logic irq_out_d;
	logic viol_out_d;
	// Qualified requests and status
	logic sec_service;
	logic sec_act;
	logic sec_deact;
	logic sec_cfg;
	logic running;
	logic expired;

	// A request counts only when the secure qualifier stands in the same cycle
	function automatic logic ssw_secure_req(
		input logic req,
		input logic secure
	);
		ssw_secure_req = req && secure;
	endfunction : ssw_secure_req

	// Normal-world requests die here, so later logic never sees them
	assign sec_service = ssw_secure_req(service, req_secure);
	assign sec_act = ssw_secure_req(activate, req_secure);
	assign sec_deact = ssw_secure_req(deactivate, req_secure);
	// A zero period would wrap and expire only after 2^32 - 1 cycles, so such a write is dropped
	assign sec_cfg = ssw_secure_req(cfg_wr, req_secure)
		&& (cfg_period != 32'h0000_0000);
	assign running = (state_q != ssw_pkg::SSW_IDLE);
	assign expired = (cnt_q == ssw_pkg::CNT_LAST);

	// Period group: a new period only takes effect at the next reload
	always_comb
	begin
		period_d = period_q;
		if (sec_cfg)
		begin
			period_d = cfg_period;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			period_q <= TIMEOUT_CYCLES;
		end
		else
		begin
			period_q <= period_d;
		end
	end

	// State group: deactivate outranks service, service outranks expiry
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ssw_pkg::SSW_IDLE:
			begin
				if (sec_act)
				begin
					state_d = ssw_pkg::SSW_RUN;
				end
			end
			ssw_pkg::SSW_RUN:
			begin
				if (sec_deact)
				begin
					state_d = ssw_pkg::SSW_IDLE;
				end
				else if (sec_service)
				begin
					state_d = ssw_pkg::SSW_RUN;
				end
				else if (expired)
				begin
					state_d = ssw_pkg::SSW_IRQ;
				end
			end
			ssw_pkg::SSW_IRQ:
			begin
				if (sec_deact)
				begin
					state_d = ssw_pkg::SSW_IDLE;
				end
				else if (sec_service)
				begin
					state_d = ssw_pkg::SSW_RUN;
				end
				else if (expired)
				begin
					state_d = ssw_pkg::SSW_VIOL;
				end
			end
			ssw_pkg::SSW_VIOL:
			begin
				// Violation is sticky until service or secure deactivation
				if (sec_deact)
				begin
					state_d = ssw_pkg::SSW_IDLE;
				end
				else if (sec_service)
				begin
					state_d = ssw_pkg::SSW_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ssw_pkg::SSW_IDLE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Counter group: counts down to one, then reloads for the next stage
	always_comb
	begin
		cnt_d = cnt_q;
		if (!running)
		begin
			if (sec_act)
			begin
				cnt_d = period_q;
			end
		end
		else if (sec_deact)
		begin
			cnt_d = ssw_pkg::CNT_RESET;
		end
		else if (sec_service)
		begin
			cnt_d = period_q;
		end
		else if (expired)
		begin
			cnt_d = period_q;
		end
		else
		begin
			cnt_d = cnt_q - 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= ssw_pkg::CNT_RESET;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end

	// Escalation group: both flags are levels cleared only by service or deactivate
	always_comb
	begin
		irq_d = irq_q;
		viol_d = viol_q;
		if (running)
		begin
			if (sec_deact)
			begin
				irq_d = 1'b0;
				viol_d = 1'b0;
			end
			else if (sec_service)
			begin
				irq_d = 1'b0;
				viol_d = 1'b0;
			end
			else if (expired)
			begin
				if (state_q == ssw_pkg::SSW_RUN)
				begin
					irq_d = 1'b1;
				end
				else
				begin
					viol_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_q <= 1'b0;
			viol_q <= 1'b0;
		end
		else
		begin
			irq_q <= irq_d;
			viol_q <= viol_d;
		end
	end

	// Output group: taken from next values so pins line up with the state registers
	always_comb
	begin
		active_d = (state_d != ssw_pkg::SSW_IDLE);
		irq_out_d = irq_d;
		viol_out_d = viol_d;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active <= 1'b0;
			secure_world_irq <= 1'b0;
			security_policy_unit_violation <= 1'b0;
		end
		else
		begin
			active <= active_d;
			secure_world_irq <= irq_out_d;
			security_policy_unit_violation <= viol_out_d;
		end
	end
endmodule : ssw_secure_starvation_watchdog

// ### testbench/ssw_chk_properties.sv
// Watchdog checker
`timescale 1ns/1ns
module ssw_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic service,
	input wire logic activate,
	input wire logic deactivate,
	input wire logic req_secure,
	input wire logic active,
	input wire logic secure_world_irq,
	input wire logic security_policy_unit_violation
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	irq_time_a: assert property (
		$rose(active) && !service ##1 !service [*3] |=> secure_world_irq) else $error("irq");
	svc_clear_a: assert property (
		service && req_secure |=> !secure_world_irq && !security_policy_unit_violation)
		else $error("clr");
	viol_after_irq_a: assert property (
		security_policy_unit_violation |-> secure_world_irq) else $error("viol without irq");
	idle_quiet_a: assert property (
		!active |-> !secure_world_irq && !security_policy_unit_violation) else $error("idle");
	nonsec_stop_a: assert property (
		active && deactivate && !req_secure |=> active) else $error("nonsec stop");
	nonsec_start_a: assert property (
		!active && activate && !req_secure |=> !active) else $error("nonsec start");
endmodule : ssw_chk
bind ssw_secure_starvation_watchdog ssw_chk ssw_chk_inst (.*);

// ### testbench/ssw_far.sv
// Policy unit model
`timescale 1ns/1ns
module ssw_far (
	input wire logic security_policy_unit_violation,
	output logic policy_alarm
);
	assign policy_alarm = security_policy_unit_violation;
endmodule : ssw_far

// ### testbench/ssw_secure_starvation_watchdog_tb_top.sv
// Watchdog bench
`timescale 1ns/1ns
module ssw_secure_starvation_watchdog_tb_top;
	logic ref_clk = 0, rst_n = 0, activate = 0, deactivate = 0, service = 0, req_secure = 0;
	logic active, secure_world_irq, security_policy_unit_violation, policy_alarm;
	logic cfg_wr = 0;
	logic [31:0] cfg_period = 32'h0;
	int bad_count, n_checks, cyc;
	always #5 ref_clk = ~ref_clk;
	ssw_secure_starvation_watchdog #(.TIMEOUT_CYCLES(32'h4))
		ssw_secure_starvation_watchdog_inst (.*);
	ssw_far ssw_far_inst (.*);
	task chk(logic [2:0] seen, exp);
		n_checks++;
		bad_count += (seen !== exp);
		if (seen !== exp)
			$display("ERROR outs exp %h got %h", exp, seen);
	endtask : chk
	task go(logic [3:0] v, int n, logic [2:0] exp);
		@(posedge ref_clk);
		{activate, deactivate, service, req_secure} <= v;
		@(posedge ref_clk);
		{activate, deactivate, service, req_secure} <= 4'h0;
		repeat (n) @(posedge ref_clk);
		#1;
		chk({active, secure_world_irq, policy_alarm}, exp);
	endtask : go
	task t_run;
		go(4'h9, 3, 3'h4);
		go(4'h0, 0, 3'h6);
		go(4'h0, 1, 3'h7);
		go(4'h3, 0, 3'h4);
		repeat (3) go(4'h3, 1, 3'h4);
		go(4'h4, 0, 3'h4);
		go(4'h0, 0, 3'h6);
		go(4'h2, 0, 3'h6);
		go(4'h5, 0, 3'h0);
		go(4'h8, 0, 3'h0);
	endtask : t_run
	task t_cfg;
		@(posedge ref_clk);
		{cfg_wr, cfg_period} <= {1'b1, 32'h0000_0002};
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		go(4'h9, 3, 3'h4);
		go(4'h0, 0, 3'h6);
		go(4'h5, 0, 3'h0);
		@(posedge ref_clk);
		{cfg_wr, req_secure} <= 2'h3;
		@(posedge ref_clk);
		{cfg_wr, req_secure} <= 2'h0;
		go(4'h9, 1, 3'h4);
		go(4'h0, 0, 3'h6);
		go(4'h5, 0, 3'h0);
	endtask : t_cfg
	task give_verdict;
		bad_count += (cyc > 200);
		$display("%0d checks %0d errors", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk)
		if (++cyc > 200)
			give_verdict;
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1;
		t_run;
		t_cfg;
		give_verdict;
	end
endmodule : ssw_secure_starvation_watchdog_tb_top
